// File: verilog/esx_exec.sv
// Execution unit for the extended stack instructions of an 8-bit core.
// Assumes the core presents each program word during phase Q1 and
// answers a data read combinationally within the same phase.
`include "esx_regs.svh"

module esx_exec
  import esx_pkg::*;
(
  // Clock and reset.
  input  wire logic                    i_core_clk,
  input  wire logic                    i_rst_n,
  // Configuration.
  input  wire logic                    i_ext_enable,
  // Instruction stream.
  input  wire logic                    i_instr_valid,
  input  wire logic [`ESX_INSTR_W-1:0] i_instr,
  // Core state.
  input  wire esx_pc_t                 i_pc,
  input  wire logic [7:0]              i_working_reg,
  input  wire logic [7:0]              i_pc_latch_high,
  input  wire logic [7:0]              i_pc_latch_upper,
  input  wire esx_pc_t                 i_return_stack_top,
  // Pointer writes by the rest of the core.
  input  wire logic                    i_ptr_we,
  input  wire logic [1:0]              i_ptr_sel,
  input  wire esx_addr_t               i_ptr_wdata,
  // Data memory.
  input  wire logic [7:0]              i_mem_rdata,
  output esx_mem_s                     o_mem,
  // Program flow.
  output esx_flow_s                    o_flow,
  // Pointers and status.
  output esx_ptrs_t                    o_ptrs,
  output logic [1:0]                   o_phase,
  output logic                         o_claim,
  output logic                         o_status_we
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  function automatic esx_addr_t idx_addr(input esx_addr_t base,
                                         input logic [6:0] off);
    idx_addr = base + {5'h00, off};
  endfunction

  function automatic logic is_indirect(input esx_addr_t a);
    is_indirect = (a >= `ESX_IND_LO) && (a <= `ESX_IND_HI);
  endfunction

  function automatic esx_addr_t ptr_sub(input esx_addr_t base,
                                        input logic [5:0] k);
    ptr_sub = base - {6'h00, k};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************

  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  esx_state_e state_r;
  esx_state_e state_nxt;
  esx_dec_s   dec_r;
  esx_dec_s   dec_nxt;
  esx_dec_s   dec;
  esx_addr_t  addr_r;
  esx_addr_t  addr_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic       skip_r;
  logic       skip_nxt;
  esx_ptrs_t  ptr_r;
  esx_ptrs_t  ptr_nxt;
  esx_mem_s   mem_r;
  esx_mem_s   mem_nxt;
  esx_flow_s  flow_r;
  esx_flow_s  flow_nxt;
  logic       claim_r;
  logic       claim_nxt;
  logic       status_we_r;
  esx_addr_t  fp;
  esx_addr_t  dst;

  // The frame pointer is the base of every indexed address.
  assign fp = ptr_r[`ESX_FP_SEL];

  esx_decode u_decode (
    .i_instr      (i_instr),
    .i_ext_enable (i_ext_enable),
    .o_dec        (dec)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  always_comb begin
    // The phase counter runs freely; zero marks phase Q1 of a cycle.
    phase_nxt        = phase_r + `ESX_PHASE_STEP;
    state_nxt        = state_r;
    dec_nxt          = dec_r;
    addr_nxt         = addr_r;
    data_nxt         = data_r;
    skip_nxt         = skip_r;
    ptr_nxt          = ptr_r;
    mem_nxt          = mem_r;
    mem_nxt.rd       = 1'b0;
    mem_nxt.wr       = 1'b0;
    flow_nxt         = flow_r;
    flow_nxt.pc_load = 1'b0;
    flow_nxt.push    = 1'b0;
    flow_nxt.pop     = 1'b0;
    dst              = `ESX_ADDR_RST;
    // A pointer update by an instruction below overrides a write from
    // the core in the same clock.
    if (i_ptr_we && (i_ptr_sel != `ESX_RET_SEL)) begin
      ptr_nxt[i_ptr_sel] = i_ptr_wdata;
    end
    case (state_r)
      ESX_IDLE: begin
        if ((phase_r == `ESX_Q1) && i_instr_valid &&
            (dec.op != ESX_OP_NONE)) begin
          dec_nxt  = dec;
          addr_nxt = idx_addr(fp, dec.off7);
          if ((dec.op == ESX_OP_MOVE_ABS) || (dec.op == ESX_OP_MOVE_IDX)) begin
            state_nxt = ESX_MOVE_RD;
          end else begin
            state_nxt = ESX_EXEC;
          end
        end
      end
      ESX_EXEC: begin
        case (phase_r)
          `ESX_Q2: begin
            if (dec_r.op == ESX_OP_CALL_WORK) begin
              flow_nxt.push      = 1'b1;
              flow_nxt.push_addr = i_pc + `ESX_PC_STEP;
            end
          end
          `ESX_Q3: begin
            if (dec_r.op == ESX_OP_PUSH) begin
              mem_nxt.wr    = 1'b1;
              mem_nxt.addr  = fp;
              mem_nxt.wdata = dec_r.lit8;
            end
          end
          `ESX_Q4: begin
            state_nxt = ESX_IDLE;
            case (dec_r.op)
              ESX_OP_PUSH: begin
                ptr_nxt[`ESX_FP_SEL] = fp - `ESX_FP_DEC;
              end
              ESX_OP_SUB: begin
                ptr_nxt[dec_r.sel] = ptr_sub(ptr_r[dec_r.sel],
                                             dec_r.k6);
              end
              ESX_OP_SUBRET: begin
                ptr_nxt[`ESX_FP_SEL] = ptr_sub(fp, dec_r.k6);
                flow_nxt.pc_load  = 1'b1;
                flow_nxt.pc_value = i_return_stack_top;
                flow_nxt.pop      = 1'b1;
                state_nxt         = ESX_NOP;
              end
              ESX_OP_CALL_WORK: begin
                flow_nxt.pc_load  = 1'b1;
                flow_nxt.pc_value = {i_pc_latch_upper[4:0],
                                     i_pc_latch_high, i_working_reg};
                state_nxt         = ESX_NOP;
              end
              default: begin
                state_nxt = ESX_IDLE;
              end
            endcase
          end
          default: begin
            state_nxt = ESX_EXEC;
          end
        endcase
      end
      ESX_MOVE_RD: begin
        // An indirect-register source is never read, so the access cannot
        // disturb a pointer; the move carries zero instead.
        if (phase_r == `ESX_Q3) begin
          mem_nxt.rd   = !is_indirect(addr_r);
          mem_nxt.addr = addr_r;
        end else if (phase_r == `ESX_Q4) begin
          data_nxt  = is_indirect(addr_r) ? `ESX_IND_READ_VAL
                                          : i_mem_rdata;
          state_nxt = ESX_MOVE_WR;
        end
      end
      ESX_MOVE_WR: begin
        // A second word that is missing or lacks the move prefix aborts
        // the move without a write.
        if (phase_r == `ESX_Q1) begin
          if (dec_r.op == ESX_OP_MOVE_IDX) begin
            dst = idx_addr(fp, i_instr[6:0]);
          end else begin
            dst = i_instr[`ESX_ADDR_W-1:0];
          end
          addr_nxt = dst;
          skip_nxt = !i_instr_valid ||
                     (i_instr[15:12] != `ESX_SECOND_NIB) ||
                     ((dec_r.op == ESX_OP_MOVE_IDX) &&
                      is_indirect(dst));
        end else if (phase_r == `ESX_Q3) begin
          mem_nxt.wr    = !skip_r;
          mem_nxt.addr  = addr_r;
          mem_nxt.wdata = data_r;
        end else if (phase_r == `ESX_Q4) begin
          state_nxt = ESX_IDLE;
        end
      end
      ESX_NOP: begin
        if (phase_r == `ESX_Q4) begin
          state_nxt = ESX_IDLE;
        end
      end
      default: begin
        state_nxt = ESX_IDLE;
      end
    endcase
    // The core holds off its own decode while the block claims the cycle.
    claim_nxt = (state_nxt != ESX_IDLE);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r         <= `ESX_Q1;
      state_r         <= ESX_IDLE;
      dec_r.op        <= ESX_OP_NONE;
      dec_r.off7      <= 7'h00;
      dec_r.lit8      <= 8'h00;
      dec_r.sel       <= 2'h0;
      dec_r.k6        <= 6'h00;
      addr_r          <= `ESX_ADDR_RST;
      data_r          <= `ESX_DATA_RST;
      skip_r          <= 1'b0;
      ptr_r           <= {3{`ESX_PTR_RST}};
      mem_r.rd        <= 1'b0;
      mem_r.wr        <= 1'b0;
      mem_r.addr      <= `ESX_ADDR_RST;
      mem_r.wdata     <= `ESX_DATA_RST;
      flow_r.pc_load  <= 1'b0;
      flow_r.pc_value <= `ESX_PC_RST;
      flow_r.push     <= 1'b0;
      flow_r.push_addr<= `ESX_PC_RST;
      flow_r.pop      <= 1'b0;
      claim_r         <= 1'b0;
      status_we_r     <= 1'b0;
    end else begin
      phase_r         <= phase_nxt;
      state_r         <= state_nxt;
      dec_r           <= dec_nxt;
      addr_r          <= addr_nxt;
      data_r          <= data_nxt;
      skip_r          <= skip_nxt;
      ptr_r           <= ptr_nxt;
      mem_r           <= mem_nxt;
      flow_r          <= flow_nxt;
      claim_r         <= claim_nxt;
      // None of these instructions ever writes the status flags.
      status_we_r     <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  assign o_mem       = mem_r;
  assign o_flow      = flow_r;
  assign o_ptrs      = ptr_r;
  assign o_phase     = phase_r;
  assign o_claim     = claim_r;
  assign o_status_we = status_we_r;

endmodule

// File: verilog/esx_regs.svh
// Constants of the extended stack instruction unit: widths, opcodes,
// phase numbers and reset values.
// Assumes inclusion by bare name from the package and the modules.
`ifndef ESX_REGS_SVH
`define ESX_REGS_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define ESX_ADDR_W       12
`define ESX_PC_W         21
`define ESX_INSTR_W      16

// ****************************************************************
// Opcode fields
// ****************************************************************
`define ESX_CALL_WORD    16'h0014
`define ESX_OP_MOVE_HI   8'hEB
`define ESX_OP_PUSH_HI   8'hFA
`define ESX_OP_SUB_HI    8'hE9
`define ESX_SECOND_NIB   4'hF
`define ESX_MOVE_KIND_B  7
`define ESX_RET_SEL      2'h3
`define ESX_FP_SEL       2'h2

// ****************************************************************
// Phases of one instruction cycle
// ****************************************************************
`define ESX_Q1           2'h0
`define ESX_Q2           2'h1
`define ESX_Q3           2'h2
`define ESX_Q4           2'h3
`define ESX_PHASE_STEP   2'h1

// ****************************************************************
// Arithmetic and reset values
// ****************************************************************
`define ESX_PC_STEP      21'h000002
`define ESX_FP_DEC       12'h001
`define ESX_IND_READ_VAL 8'h00
`define ESX_IND_LO       12'hFD8
`define ESX_IND_HI       12'hFEF
`define ESX_PTR_RST      12'h000
`define ESX_PC_RST       21'h000000
`define ESX_ADDR_RST     12'h000
`define ESX_DATA_RST     8'h00

`endif

// File: verilog/esx_pkg.sv
// Types shared by the extended stack instruction unit.
// Assumes esx_regs.svh is on the include path.
`include "esx_regs.svh"

package esx_pkg;

  typedef logic [`ESX_ADDR_W-1:0]       esx_addr_t;
  typedef logic [`ESX_PC_W-1:0]         esx_pc_t;
  typedef logic [2:0][`ESX_ADDR_W-1:0]  esx_ptrs_t;

  typedef enum logic [2:0] {
    ESX_IDLE    = 3'b000,
    ESX_EXEC    = 3'b001,
    ESX_MOVE_RD = 3'b010,
    ESX_MOVE_WR = 3'b011,
    ESX_NOP     = 3'b100
  } esx_state_e;

  typedef enum logic [2:0] {
    ESX_OP_NONE      = 3'b000,
    ESX_OP_CALL_WORK = 3'b001,
    ESX_OP_MOVE_ABS  = 3'b010,
    ESX_OP_MOVE_IDX  = 3'b011,
    ESX_OP_PUSH      = 3'b100,
    ESX_OP_SUB       = 3'b101,
    ESX_OP_SUBRET    = 3'b110
  } esx_op_e;

  typedef struct packed {
    esx_op_e    op;
    logic [6:0] off7;
    logic [7:0] lit8;
    logic [1:0] sel;
    logic [5:0] k6;
  } esx_dec_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    esx_addr_t  addr;
    logic [7:0] wdata;
  } esx_mem_s;

  typedef struct packed {
    logic    pc_load;
    esx_pc_t pc_value;
    logic    push;
    esx_pc_t push_addr;
    logic    pop;
  } esx_flow_s;

endpackage

// File: verilog/esx_decode.sv
// Opcode decoder of the extended stack instruction unit.
// Assumes a full instruction word and the extension enable are stable.
`include "esx_regs.svh"

module esx_decode
  import esx_pkg::*;
(
  // Instruction and configuration.
  input  wire logic [`ESX_INSTR_W-1:0] i_instr,
  input  wire logic                    i_ext_enable,
  // Decoded fields.
  output esx_dec_s                     o_dec
);

  logic [7:0] hi_byte;

  assign hi_byte = i_instr[15:8];

  always_comb begin
    o_dec.op   = ESX_OP_NONE;
    o_dec.off7 = i_instr[6:0];
    o_dec.lit8 = i_instr[7:0];
    o_dec.sel  = i_instr[7:6];
    o_dec.k6   = i_instr[5:0];
    if (i_ext_enable) begin
      if (i_instr == `ESX_CALL_WORD) begin
        o_dec.op = ESX_OP_CALL_WORK;
      end else if (hi_byte == `ESX_OP_MOVE_HI) begin
        o_dec.op = i_instr[`ESX_MOVE_KIND_B] ? ESX_OP_MOVE_IDX
                                             : ESX_OP_MOVE_ABS;
      end else if (hi_byte == `ESX_OP_PUSH_HI) begin
        o_dec.op = ESX_OP_PUSH;
      end else if (hi_byte == `ESX_OP_SUB_HI) begin
        o_dec.op = (i_instr[7:6] == `ESX_RET_SEL) ? ESX_OP_SUBRET
                                                  : ESX_OP_SUB;
      end
    end
  end

endmodule

// File: testbench/esx_exec_assertions.sv
// Assertions of the extended stack instruction unit.
// Assumes the bind below attaches it to the unit's ports.
`include "esx_regs.svh"

module esx_exec_checker
  import esx_pkg::*;
(
  // Clock and reset.
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  // Inputs of the unit.
  input wire logic        i_ext_enable,
  input wire logic        i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire esx_pc_t     i_pc,
  input wire logic [7:0]  i_working_reg,
  input wire logic [7:0]  i_pc_latch_high,
  input wire logic [7:0]  i_pc_latch_upper,
  input wire esx_pc_t     i_return_stack_top,
  // Outputs of the unit.
  input wire esx_mem_s    o_mem,
  input wire esx_flow_s   o_flow,
  input wire esx_ptrs_t   o_ptrs,
  input wire logic [1:0]  o_phase,
  input wire logic        o_claim
);
  logic take;
  logic ret;
  logic call;

  // An instruction word is accepted on this edge.
  assign take = o_phase == 2'h0 && !o_claim && i_instr_valid && i_ext_enable;
  assign ret  = i_instr[15:6] == 10'h3A7;
  assign call = i_instr == 16'h0014;

  default clocking dc @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_push_write: assert property (
    take && i_instr[15:8] == 8'hFA |-> ##3 o_mem.wr
    && o_mem.addr == $past(o_ptrs[2], 3)
    && o_mem.wdata == $past(i_instr[7:0], 3)) else $error("push write");
  a_push_step: assert property (
    take && i_instr[15:8] == 8'hFA
    |-> ##4 o_ptrs[2] == $past(o_ptrs[2], 4) - 12'h001) else $error("push");
  a_sub_ptr: assert property (
    take && i_instr[15:8] == 8'hE9 && !ret |-> ##4
    o_ptrs[$past(i_instr[7:6], 4)] == $past(o_ptrs[i_instr[7:6]], 4)
    - {6'h00, $past(i_instr[5:0], 4)}) else $error("subtract");
  a_sub_return: assert property (
    take && ret |-> ##4 o_flow.pc_load && o_flow.pop
    && o_flow.pc_value == $past(i_return_stack_top)
    && o_ptrs[2] == $past(o_ptrs[2], 4) - {6'h00, $past(i_instr[5:0], 4)})
    else $error("return");
  a_claim_length: assert property (
    take && (ret || call) |=> o_claim [*7] ##1 !o_claim)
    else $error("claim length");
  a_call_push: assert property (
    take && call |-> ##2 o_flow.push
    && o_flow.push_addr == $past(i_pc) + 21'h000002) else $error("call");
  a_call_target: assert property (
    take && call |-> ##4 o_flow.pc_load && o_flow.pc_value
    == {$past(i_pc_latch_upper[4:0]), $past(i_pc_latch_high),
    $past(i_working_reg)}) else $error("call target");
  a_move_read: assert property (
    take && i_instr[15:8] == 8'hEB |-> ##3 o_mem.addr
    == $past(o_ptrs[2], 3) + {5'h00, $past(i_instr[6:0], 3)}
    && o_mem.rd == !(o_mem.addr >= 12'hFD8 && o_mem.addr <= 12'hFEF))
    else $error("move read");
  a_move_dest: assert property (
    (take && i_instr[15:7] == 9'h1D6) ##4
    (i_instr_valid && i_instr[15:12] == 4'hF)
    |-> ##3 o_mem.wr && o_mem.addr == $past(i_instr[11:0], 3))
    else $error("move write");
  a_ext_off: assert property (
    o_phase == 2'h0 && !o_claim && !i_ext_enable |=> !o_claim)
    else $error("claim while off");
endmodule

bind esx_exec esx_exec_checker u_chk (.i_core_clk, .i_rst_n,
  .i_ext_enable, .i_instr_valid, .i_instr, .i_pc, .i_working_reg,
  .i_pc_latch_high, .i_pc_latch_upper, .i_return_stack_top, .o_mem,
  .o_flow, .o_ptrs, .o_phase, .o_claim);

// File: testbench/esx_exec_tb.sv
// Self-checking bench of the extended stack instruction unit.
// Assumes the checker file binds itself to the unit.
`include "esx_regs.svh"

module testbench
  import esx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst_n, ext, vld, pwe, claim, stw;
  logic [1:0]  psel, phase;
  logic [7:0]  work, lath, latu, rdata;
  logic [15:0] instr, seed, a, b;
  esx_addr_t   pwd;
  esx_pc_t     pc, stk, pl_v, push_v;
  esx_mem_s    mem, wr_v;
  esx_flow_s   flow;
  esx_ptrs_t   ptrs;
  int          error_cnt, check_count, wr_n, pl_n, push_n, pop_n;

  esx_exec dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_ext_enable(ext),
    .i_instr_valid(vld), .i_instr(instr), .i_pc(pc),
    .i_working_reg(work), .i_pc_latch_high(lath),
    .i_pc_latch_upper(latu), .i_return_stack_top(stk),
    .i_ptr_we(pwe), .i_ptr_sel(psel), .i_ptr_wdata(pwd),
    .i_mem_rdata(rdata), .o_mem(mem), .o_flow(flow), .o_ptrs(ptrs),
    .o_phase(phase), .o_claim(claim), .o_status_we(stw));

  function automatic logic win(esx_addr_t x);
    return x >= `ESX_IND_LO && x <= `ESX_IND_HI;
  endfunction
  function automatic logic [7:0] pat(esx_addr_t x);
    return x[7:0] ^ {x[11:8], x[11:8]} ^ 8'hA5;
  endfunction
  function automatic logic [7:0] src(esx_addr_t x);
    return win(x) ? 8'h00 : pat(x);
  endfunction
  function automatic logic [20:0] z(esx_addr_t x);
    return {9'h000, x};
  endfunction
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // Memory returns a pattern while read, its inverse otherwise.
  assign rdata = mem.rd ? pat(mem.addr) : ~pat(mem.addr);
  always #12.5 clk = ~clk;

  always @(negedge clk) begin
    if (mem.wr === 1'b1) begin
      wr_n++;
      wr_v = mem;
    end
    if (flow.pc_load === 1'b1) begin
      pl_n++;
      pl_v = flow.pc_value;
    end
    if (flow.push === 1'b1) begin
      push_n++;
      push_v = flow.push_addr;
    end
    if (flow.pop === 1'b1) pop_n++;
    if (stw !== 1'b0) chk("status write", 21'h000000, 21'(stw));
  end

  task automatic chk(string s, logic [20:0] e, logic [20:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic idle();
    for (int n = 0; n < 24; n++) begin
      @(negedge clk);
      if (phase === 2'h0 && claim === 1'b0) return;
    end
    chk("idle", 21'h000001, 21'h000000);
    end_of_test();
  endtask

  task automatic issue(logic [15:0] w1, logic [15:0] w2, logic two);
    {wr_n, pl_n, push_n, pop_n} = '0;
    instr = w1;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    instr = rnd();
    if (two) begin
      repeat (3) @(negedge clk);
      instr = w2;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
    end
    idle();
  endtask

  task automatic set_ptr(logic [1:0] s, esx_addr_t v);
    psel = s;
    pwd = v;
    pwe = 1'b1;
    @(negedge clk);
    pwe = 1'b0;
    chk("pointer", z(v), z(ptrs[s]));
    idle();
  endtask

  task automatic do_push(esx_addr_t p, logic [7:0] k);
    set_ptr(2'h2, p);
    issue({8'hFA, k}, 16'h0000, 1'b0);
    chk("push count", 21'h000001, 21'(wr_n));
    chk("push addr", z(p), z(wr_v.addr));
    chk("push data", 21'(k), 21'(wr_v.wdata));
    chk("push fp", z(p - 12'h001), z(ptrs[2]));
  endtask

  task automatic do_sub(logic [1:0] f, esx_addr_t v, logic [5:0] k);
    logic [1:0] p;
    p = (f == 2'h3) ? 2'h2 : f;
    stk = 21'({rnd(), rnd()});
    set_ptr(p, v);
    issue({8'hE9, f, k}, 16'h0000, 1'b0);
    chk("sub ptr", z(v - {6'h00, k}), z(ptrs[p]));
    chk("pop count", 21'(f == 2'h3), 21'(pop_n));
    chk("load count", 21'(f == 2'h3), 21'(pl_n));
    if (f == 2'h3) chk("return", stk, pl_v);
  endtask

  task automatic do_move(logic s, esx_addr_t p, logic [6:0] o,
                         logic [15:0] w);
    esx_addr_t d;
    logic      ok;
    d = s ? p + {5'h00, w[6:0]} : w[11:0];
    ok = w[15:12] == 4'hF && !(s && win(d));
    set_ptr(2'h2, p);
    issue({8'hEB, s, o}, w, 1'b1);
    chk("move count", 21'(ok), 21'(wr_n));
    if (ok) begin
      chk("move dest", z(d), z(wr_v.addr));
      chk("move data", 21'(src(p + {5'h00, o})), 21'(wr_v.wdata));
    end
  endtask

  initial begin
    {clk, rst_n, vld, pwe, psel, pwd, instr, pc, stk} = '0;
    {work, lath, latu} = '0;
    ext = 1'b1;
    seed = 16'h005E;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk("fp reset", 21'h000000, z(ptrs[2]));
    idle();
    do_push(12'h000, 8'hFF);
    do_push(12'h1EC, 8'h08);
    $display("test push finished");
    for (int f = 0; f < 4; f++) begin
      do_sub(2'(f), 12'h000, 6'h3F);
      do_sub(2'(f), 12'h3FF, 6'h23);
    end
    $display("test subtract finished");
    pc = 21'({rnd(), rnd()});
    work = 8'(rnd());
    lath = 8'(rnd());
    latu = 8'(rnd());
    issue(16'h0014, 16'h0000, 1'b0);
    chk("call push", pc + 21'h000002, push_v);
    chk("call target", {latu[4:0], lath, work}, pl_v);
    $display("test call finished");
    do_move(1'b0, 12'hFD0, 7'h08, 16'hF123);
    do_move(1'b0, 12'hF80, 7'h7F, 16'hF000);
    do_move(1'b0, 12'h000, 7'h00, 16'hF7FE);
    do_move(1'b1, 12'hFD0, 7'h01, 16'hF008);
    do_move(1'b1, 12'hFFF, 7'h7F, 16'hFFFF);
    do_move(1'b0, 12'h080, 7'h05, 16'hE123);
    $display("test move finished");
    ext = 1'b0;
    set_ptr(2'h2, 12'h100);
    issue(16'hFA55, 16'h0000, 1'b0);
    chk("off writes", 21'h000000, 21'(wr_n));
    chk("off fp", z(12'h100), z(ptrs[2]));
    ext = 1'b1;
    $display("test disabled finished");
    for (int i = 0; i < 40; i++) begin
      a = rnd();
      b = rnd();
      case (a[1:0])
        2'h0: do_push(b[11:0], a[15:8]);
        2'h1: do_sub(a[3:2], b[11:0], b[15:10]);
        default: do_move(a[0], b[11:0], a[14:8],
                         {5'h1E, b[2:0], a[15:8]});
      endcase
    end
    $display("test random finished");
    end_of_test();
  end
endmodule
